// *** serial_pkg.sv ***
// shared constants and types for the async serial interface
`default_nettype none
package serial_pkg;
	localparam int ADDR_W = 12;
	// register byte addresses
	localparam logic [11:0] OFS_DATA = 12'h000;
	localparam logic [11:0] OFS_CTRL = 12'h004;
	localparam logic [11:0] OFS_BAUD = 12'h008;
	localparam logic [11:0] OFS_STATUS = 12'h00C;
	localparam logic [11:0] OFS_MASK = 12'h010;
	// control field positions
	localparam int CTRL_NINE = 0;
	localparam int CTRL_TX_EN = 1;
	localparam int CTRL_RX_EN = 2;
	localparam int CTRL_TX9 = 3;
	localparam int CTRL_W = 4;
	// status / mask field positions
	localparam int ST_TXE = 0;
	localparam int ST_TXD = 1;
	localparam int ST_RXF = 2;
	localparam int ST_OVR = 3;
	localparam int ST_W = 4;
	// baud register: divisor in low bits, source select at bit 16
	localparam int BAUD_DIV_W = 16;
	localparam int BAUD_SRC = 16;
	localparam logic [15:0] BAUD_DIV_RST = 16'h001A;
	localparam logic [15:0] ALT_PRE_DIV = 16'h0004;
	// receiver oversampling
	localparam logic [3:0] OVS_LAST = 4'hF;
	localparam logic [3:0] OVS_MID = 4'h7;
	localparam logic [3:0] BITS_8 = 4'h8;
	localparam logic [3:0] BITS_9 = 4'h9;
	typedef enum logic [3:0] {
		RX_IDLE = 4'b0001,
		RX_START = 4'b0010,
		RX_DATA = 4'b0100,
		RX_STOP = 4'b1000
	} rx_state_t;
endpackage
`default_nettype wire

// *** baud_if.sv ***
// tick bundle from the shared baud generator
`default_nettype none
interface baud_if;
	logic tick16;
	modport gen(output tick16);
	modport use_side(input tick16);
endinterface
`default_nettype wire

// *** baud_gen.sv ***
// shared 16x baud tick generator with selectable source
`default_nettype none
module baud_gen (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic src_sel,
	input wire logic [15:0] divisor,
	baud_if.gen bo
);
	logic [15:0] pre_r, pre_nxt, cnt_r, cnt_nxt;
	logic tick_r, tick_nxt;
	logic src_en;
	// source 0 is pclk, source 1 a prescaled pclk
	always_comb begin
		pre_nxt = (pre_r == serial_pkg::ALT_PRE_DIV - 16'h0001) ? 16'h0000 : pre_r + 16'h0001;
		src_en = src_sel ? (pre_r == 16'h0000) : 1'b1;
		cnt_nxt = cnt_r;
		tick_nxt = 1'b0;
		if (src_en) begin
			if (cnt_r >= divisor - 16'h0001) begin
				cnt_nxt = 16'h0000;
				tick_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r + 16'h0001;
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_r <= 16'h0000;
			cnt_r <= 16'h0000;
			tick_r <= 1'b0;
		end else begin
			pre_r <= pre_nxt;
			cnt_r <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end
	assign bo.tick16 = tick_r;
endmodule
`default_nettype wire

// *** async_serial_interface.sv ***
// apb uart: tx, rx, shared baud generator, irq
//
// Our own choices: the APB slave port and the placing of the registers.
`default_nettype none
// Behaviour
// [RL1] full-duplex link, transmitter and receiver run independently
// [RL2] both engines use one shared baud tick generator
// [RL3] NRZ mark/space line levels, both ends agree
// [RL4] baud_source_select picks one of two clocks for the baud generator
// [RL5] no infrared coding here; plain serial in and out
// [RL6] 8 or 9 data bits sent; ninth from tx_ninth_bit
// [RL7] buffer-empty flag set when buffer moves to shifter; irq if enabled
// [RL8] done flag when shifter and buffer empty and idle; irq if enabled
// [RL9] receiver uses the same word-size bit
// [RL10] rx_ninth_bit holds bit 8, or copy of bit 7 in 8-bit mode
// [RL11] rx full with enable raises receive interrupt
// [RL12] low start, lsb first data, high stop, idle high
module async_serial_interface (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxd,
	output logic txd,
	output logic irq
);
	baud_if bi();
	logic [3:0] ctrl_r, ctrl_nxt;
	logic [16:0] baud_r, baud_nxt;
	logic [3:0] stat_r, stat_nxt, mask_r, mask_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic wr, rd, hit;
	logic nine;
	// tx state
	logic [8:0] tbuf_r, tbuf_nxt;
	logic tbuf_full_r, tbuf_full_nxt;
	logic [10:0] tsh_r, tsh_nxt;
	logic [3:0] tbits_r, tbits_nxt, tph_r, tph_nxt;
	logic tbusy_r, tbusy_nxt;
	logic txd_r, txd_nxt;
	logic ev_txe, ev_txd;
	// rx state
	logic rx_m_r, rx_s_r;
	serial_pkg::rx_state_t rst_r, rst_nxt;
	logic [3:0] rph_r, rph_nxt, rbits_r, rbits_nxt;
	logic [8:0] rsh_r, rsh_nxt, rdat_r, rdat_nxt;
	logic ev_rxf, ev_ovr;
	// write strobes, one per register
	logic wr_data, wr_ctrl, wr_baud, wr_stat, wr_mask;

	// address compare shared by every write strobe
	function automatic logic reg_is(input logic [11:0] a, input logic [11:0] ofs);
		return a == ofs;
	endfunction

	// start, data lsb first, stop; spare top bit idle high in 8-bit frames
	function automatic logic [10:0] tx_frame(input logic nine_m, input logic [8:0] d);
		if (nine_m) begin
			return {1'b1, d, 1'b0};
		end
		return {2'b11, d[7:0], 1'b0};
	endfunction

	// 8-bit frames land in the top of the shifter; bit 7 doubles as ninth
	function automatic logic [8:0] rx_word(input logic nine_m, input logic [8:0] sh);
		if (nine_m) begin
			return sh;
		end
		return {sh[8], sh[8:1]};
	endfunction

	baud_gen u_baud (
		.pclk(pclk),
		.presetn(presetn),
		.src_sel(baud_r[serial_pkg::BAUD_SRC]), // RL4
		.divisor(baud_r[15:0]),
		.bo(bi.gen)
	);

	assign nine = ctrl_r[serial_pkg::CTRL_NINE];
	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	assign pready = 1'b1;
	// decoded once so every group sees the same access
	assign wr_data = wr && reg_is(paddr, serial_pkg::OFS_DATA);
	assign wr_ctrl = wr && reg_is(paddr, serial_pkg::OFS_CTRL);
	assign wr_baud = wr && reg_is(paddr, serial_pkg::OFS_BAUD);
	assign wr_stat = wr && reg_is(paddr, serial_pkg::OFS_STATUS);
	assign wr_mask = wr && reg_is(paddr, serial_pkg::OFS_MASK);
	// unmapped addresses flag an error in the access phase
	always_comb begin
		unique case (paddr)
			serial_pkg::OFS_DATA, serial_pkg::OFS_CTRL, serial_pkg::OFS_BAUD,
			serial_pkg::OFS_STATUS, serial_pkg::OFS_MASK: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end
	assign pslverr = psel && penable && !hit;

	// control, baud and mask registers
	always_comb begin
		ctrl_nxt = ctrl_r;
		baud_nxt = baud_r;
		mask_nxt = mask_r;
		if (wr_ctrl) ctrl_nxt = pwdata[serial_pkg::CTRL_W-1:0];
		if (wr_baud) begin
			baud_nxt = pwdata[serial_pkg::BAUD_SRC:0];
			if (pwdata[serial_pkg::BAUD_DIV_W-1:0] == 16'h0000) begin
				baud_nxt[15:0] = 16'h0001; // zero divisor would divide by 65536
			end
		end
		if (wr_mask) mask_nxt = pwdata[serial_pkg::ST_W-1:0];
	end

	// read data loaded in setup, held through the access phase
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (psel && !penable && !pwrite) begin
			unique case (paddr)
				serial_pkg::OFS_DATA: rdata_nxt = {23'h000000, rdat_r};
				serial_pkg::OFS_CTRL: rdata_nxt = {28'h0000000, ctrl_r};
				serial_pkg::OFS_BAUD: rdata_nxt = {15'h0000, baud_r};
				serial_pkg::OFS_STATUS: rdata_nxt = {28'h0000000, stat_r};
				serial_pkg::OFS_MASK: rdata_nxt = {28'h0000000, mask_r};
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end else if (rd) begin
			rdata_nxt = rdata_r;
		end
	end
	assign prdata = rdata_r;

	// sticky status: set wins over write-one-to-clear
	always_comb begin
		stat_nxt = stat_r;
		if (wr_stat) stat_nxt = stat_r & ~pwdata[serial_pkg::ST_W-1:0];
		if (ev_txe) stat_nxt[serial_pkg::ST_TXE] = 1'b1; // RL7
		if (ev_txd) stat_nxt[serial_pkg::ST_TXD] = 1'b1; // RL8
		if (ev_rxf) stat_nxt[serial_pkg::ST_RXF] = 1'b1;
		if (ev_ovr) stat_nxt[serial_pkg::ST_OVR] = 1'b1;
	end
	// one level output over masked status
	assign irq = |(stat_r & mask_r); // RL7 RL8 RL11

	// transmitter: buffer then shifter, independent of rx
	always_comb begin
		tbuf_nxt = tbuf_r;
		tbuf_full_nxt = tbuf_full_r;
		tsh_nxt = tsh_r;
		tbits_nxt = tbits_r;
		tph_nxt = tph_r;
		tbusy_nxt = tbusy_r;
		txd_nxt = txd_r;
		ev_txe = 1'b0;
		ev_txd = 1'b0;
		if (wr_data && !tbuf_full_r) begin
			// ninth bit latched with the data, write ignored while buffer full
			tbuf_nxt = {ctrl_r[serial_pkg::CTRL_TX9], pwdata[7:0]}; // RL6
			tbuf_full_nxt = 1'b1;
		end
		if (tbusy_r && bi.tick16) begin // RL2
			if (tph_r == serial_pkg::OVS_LAST) begin
				tph_nxt = 4'h0;
				if (tbits_r == 4'h0) begin
					tbusy_nxt = 1'b0;
					txd_nxt = 1'b1; // RL12
					if (!tbuf_full_r) ev_txd = 1'b1; // RL8
				end else begin
					txd_nxt = tsh_r[0]; // RL3 RL5
					tsh_nxt = {1'b1, tsh_r[10:1]};
					tbits_nxt = tbits_r - 4'h1;
				end
			end else begin
				tph_nxt = tph_r + 4'h1;
			end
		end else if (!tbusy_r && tbuf_full_r && ctrl_r[serial_pkg::CTRL_TX_EN]) begin
			// start bit, data lsb first, stop bit
			tsh_nxt = tx_frame(nine, tbuf_r); // RL6 RL12
			tbits_nxt = nine ? serial_pkg::BITS_9 + 4'h2 : serial_pkg::BITS_8 + 4'h2;
			tph_nxt = serial_pkg::OVS_LAST;
			tbusy_nxt = 1'b1;
			tbuf_full_nxt = 1'b0;
			ev_txe = 1'b1; // RL7
		end
	end

	// double-flop the line before use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_m_r <= 1'b1;
			rx_s_r <= 1'b1;
		end else begin
			rx_m_r <= rxd;
			rx_s_r <= rx_m_r;
		end
	end

	// receiver: 16x oversampled, mid-bit sampling
	always_comb begin
		rst_nxt = rst_r;
		rph_nxt = rph_r;
		rbits_nxt = rbits_r;
		rsh_nxt = rsh_r;
		rdat_nxt = rdat_r;
		ev_rxf = 1'b0;
		ev_ovr = 1'b0;
		if (bi.tick16) begin // RL2
			unique case (rst_r)
				serial_pkg::RX_IDLE: begin
					if (!rx_s_r && ctrl_r[serial_pkg::CTRL_RX_EN]) begin // RL12
						rst_nxt = serial_pkg::RX_START;
						rph_nxt = 4'h0;
					end
				end
				serial_pkg::RX_START: begin
					if (rph_r == serial_pkg::OVS_MID) begin
						// glitch shorter than half a bit is dropped
						rst_nxt = rx_s_r ? serial_pkg::RX_IDLE : serial_pkg::RX_DATA;
						rph_nxt = 4'h0;
						rbits_nxt = nine ? serial_pkg::BITS_9 : serial_pkg::BITS_8; // RL9
					end else begin
						rph_nxt = rph_r + 4'h1;
					end
				end
				serial_pkg::RX_DATA: begin
					if (rph_r == serial_pkg::OVS_LAST) begin
						rph_nxt = 4'h0;
						rsh_nxt = {rx_s_r, rsh_r[8:1]}; // RL3
						rbits_nxt = rbits_r - 4'h1;
						if (rbits_r == 4'h1) rst_nxt = serial_pkg::RX_STOP;
					end else begin
						rph_nxt = rph_r + 4'h1;
					end
				end
				serial_pkg::RX_STOP: begin
					if (rph_r == serial_pkg::OVS_LAST) begin
						rst_nxt = serial_pkg::RX_IDLE;
						if (rx_s_r) begin // bad stop bit drops the character
							if (stat_r[serial_pkg::ST_RXF]) ev_ovr = 1'b1;
							// 8-bit frames land in rsh[8:1]; bit 7 copied as ninth
							rdat_nxt = rx_word(nine, rsh_r); // RL10
							ev_rxf = 1'b1; // RL11
						end
					end else begin
						rph_nxt = rph_r + 4'h1;
					end
				end
				default: rst_nxt = serial_pkg::RX_IDLE;
			endcase
		end
	end
	assign txd = txd_r;

	// configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= 4'h0;
			baud_r <= {1'b0, serial_pkg::BAUD_DIV_RST};
			mask_r <= 4'h0;
		end else begin
			ctrl_r <= ctrl_nxt;
			baud_r <= baud_nxt;
			mask_r <= mask_nxt;
		end
	end

	// read data register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_r <= 32'h0000_0000;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// sticky status bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_r <= 4'h0;
		end else begin
			stat_r <= stat_nxt;
		end
	end

	// transmitter state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tbuf_r <= 9'h000;
			tbuf_full_r <= 1'b0;
			tsh_r <= 11'h7FF;
			tbits_r <= 4'h0;
			tph_r <= 4'h0;
			tbusy_r <= 1'b0;
			txd_r <= 1'b1;
		end else begin
			tbuf_r <= tbuf_nxt;
			tbuf_full_r <= tbuf_full_nxt;
			tsh_r <= tsh_nxt;
			tbits_r <= tbits_nxt;
			tph_r <= tph_nxt;
			tbusy_r <= tbusy_nxt;
			txd_r <= txd_nxt;
		end
	end

	// receiver state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_r <= serial_pkg::RX_IDLE;
			rph_r <= 4'h0;
			rbits_r <= 4'h0;
			rsh_r <= 9'h000;
			rdat_r <= 9'h000;
		end else begin
			rst_r <= rst_nxt;
			rph_r <= rph_nxt;
			rbits_r <= rbits_nxt;
			rsh_r <= rsh_nxt;
			rdat_r <= rdat_nxt;
		end
	end
endmodule
`default_nettype wire

// *** async_serial_interface_monitor.sv ***
// pin-level checks for the serial block
`default_nettype none
module async_serial_interface_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic txd,
	input wire logic irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// access phase and unmapped decode
	wire logic acc = psel && penable;
	wire logic unm = paddr[1:0] != 2'h0 || paddr > serial_pkg::OFS_MASK;
	a_ready_always: assert property (psel |-> pready)
		else $error("pready low");
	a_err_unmapped: assert property (acc && unm |-> pslverr)
		else $error("no error response");
	a_err_mapped: assert property (acc && !unm |-> !pslverr)
		else $error("false error response");
	a_unmapped_zero: assert property (acc && unm && !pwrite |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	// every bit lasts at least 16 clocks, so 8 is a safe floor
	a_start_width: assert property ($fell(txd) |-> !txd [*8])
		else $error("low bit too short");
	a_mark_width: assert property ($rose(txd) |-> txd [*8])
		else $error("high bit too short");
	a_idle_reset: assert property ($rose(presetn) |-> txd && !irq)
		else $error("line or irq wrong after reset");
	a_mask_quiet: assert property (acc && pwrite && paddr == serial_pkg::OFS_MASK &&
		pwdata[3:0] == 4'h0 |=> !irq)
		else $error("irq with all masked");
	cover property ($fell(txd));
	cover property ($rose(irq));
	cover property (acc && unm);
endmodule
bind async_serial_interface async_serial_interface_monitor i_mon (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .txd(txd),
	.irq(irq));
`default_nettype wire

// *** serial_peer.sv ***
// remote serial device model
`default_nettype none
module serial_peer (
	input wire logic clk,
	input wire logic line_in,
	output logic line_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial line_out = 1'b1;
	// one frame out; a low stop level only for refusal tests
	task automatic send(input logic [8:0] d, input int n, input int bt, input logic stp);
		@(posedge clk);
		line_out <= 1'b0;
		repeat (bt) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			line_out <= d[i];
			repeat (bt) @(posedge clk);
		end
		line_out <= stp;
		repeat (bt) @(posedge clk);
		line_out <= 1'b1;
		repeat (bt) @(posedge clk);
	endtask
	// mid-bit sampling; stop level lands above the data bits
	task automatic recv(input int n, input int bt, output logic [9:0] d);
		int t;
		d = '0;
		t = 0;
		while (line_in !== 1'b0 && t < 20000) begin
			@(posedge clk);
			t++;
		end
		repeat (bt / 2) @(posedge clk);
		for (int i = 0; i <= n; i++) begin
			repeat (bt) @(posedge clk);
			d[i] = line_in;
		end
	endtask
endmodule
`default_nettype wire

// *** async_serial_interface_tb_top.sv ***
// self-checking bench for the serial block
`default_nettype none
module async_serial_interface_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rv;
	logic pready, pslverr, rxd, txd, irq;
	logic [9:0] fr, fr2;
	int err_total = 0, cmp_count = 0, bt = 16;
	async_serial_interface i_async_serial_interface (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq));
	serial_peer i_serial_peer (.clk(pclk), .line_in(txd), .line_out(rxd));
	initial forever #10 pclk = ~pclk;
	// one apb transfer; read data taken at the completing edge
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rv = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rv, e);
	endtask
	task automatic results;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// one character out; empty flag masked, done flag unmasked
	task automatic tx(input logic [31:0] ctl, input int n, input logic [7:0] b);
		xfer(1'b1, serial_pkg::OFS_CTRL, ctl);
		fork
			i_serial_peer.recv(n, bt, fr);
			begin
				xfer(1'b1, serial_pkg::OFS_DATA, {24'h0, b});
				rdc(serial_pkg::OFS_STATUS, 32'h1);
				chk(irq, 0);
			end
		join
		chk(fr, n == 9 ? {1'b1, ctl[3], b} : {2'b01, b});
		repeat (bt) @(posedge pclk);
		rdc(serial_pkg::OFS_STATUS, 32'h3);
		chk(irq, 1);
		xfer(1'b1, serial_pkg::OFS_STATUS, 32'hF);
		rdc(serial_pkg::OFS_STATUS, 32'h0);
		chk(irq, 0);
	endtask
	task automatic rx(input logic [31:0] ctl, input int n, input logic [8:0] d, input int e);
		xfer(1'b1, serial_pkg::OFS_CTRL, ctl);
		i_serial_peer.send(d, n, bt, 1'b1);
		rdc(serial_pkg::OFS_STATUS, 32'h4);
		chk(irq, 1);
		rdc(serial_pkg::OFS_DATA, e);
		xfer(1'b1, serial_pkg::OFS_STATUS, 32'hF);
	endtask
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b1, serial_pkg::OFS_MASK, 32'h0);
		rdc(serial_pkg::OFS_CTRL, 32'h0);
		rdc(serial_pkg::OFS_BAUD, 32'h1A);
		rdc(serial_pkg::OFS_STATUS, 32'h0);
		rdc(12'h014, 32'h0);
		chk(txd, 1);
		xfer(1'b1, serial_pkg::OFS_MASK, 32'h6);
		// second pass on the divided source: both engines slow down
		for (int k = 0; k < 2; k++) begin
			xfer(1'b1, serial_pkg::OFS_BAUD, k ? 32'h10001 : 32'h1);
			bt = k ? 64 : 16;
			tx(32'h6, 8, 8'hA5);
			tx(32'hF, 9, 8'h3C);
			rx(32'h6, 8, 9'h081, 32'h181);
			rx(32'h6, 8, 9'h07E, 32'h07E);
			rx(32'h7, 9, 9'h1C3, 32'h1C3);
			rx(32'h7, 9, 9'h0C3, 32'h0C3);
		end
		// second byte queued while the first shifts
		xfer(1'b1, serial_pkg::OFS_CTRL, 32'h6);
		fork
			begin
				i_serial_peer.recv(8, bt, fr);
				i_serial_peer.recv(8, bt, fr2);
			end
			begin
				xfer(1'b1, serial_pkg::OFS_DATA, 32'h11);
				xfer(1'b1, serial_pkg::OFS_DATA, 32'h22);
			end
		join
		chk(fr, 10'h111);
		chk(fr2, 10'h122);
		repeat (2 * bt) @(posedge pclk);
		xfer(1'b1, serial_pkg::OFS_STATUS, 32'hF);
		// two characters unread: the second overruns and overwrites
		i_serial_peer.send(9'h055, 8, bt, 1'b1);
		i_serial_peer.send(9'h033, 8, bt, 1'b1);
		rdc(serial_pkg::OFS_STATUS, 32'hC);
		chk(irq, 1);
		rdc(serial_pkg::OFS_DATA, 32'h033);
		xfer(1'b1, serial_pkg::OFS_STATUS, 32'hF);
		i_serial_peer.send(9'h0AA, 8, bt, 1'b0);
		rdc(serial_pkg::OFS_STATUS, 32'h0);
		results;
	end
	initial begin
		repeat (60000) @(posedge pclk);
		err_total++;
		results;
	end
endmodule
`default_nettype wire
